/* design/iolm_top.v */
// i/o line function select, input filter choice, pull-down and output-write gating
// What this block does
// - the pull-up state register reads 0 for a line whose pull-up is on and 1 where it is off.
// - each line's function comes from its bit pair in the two select registers: 00 A, low B, high C, both D.
// - with write protection on, writes to both select registers, pull-down on/off and gate on/off are dropped.
// - a 1 written into the glitch-select register puts that line on the clock-rate glitch filter.
// - a 1 written into the debounce-select register puts that line on the slow-clock debouncer.
// - the filter status register reads 0 for a glitch-filtered line and 1 for a debounced line.
// - the debounce period is (divider+1)*2 slow-clock periods, divider in bits 13..0, upper bits reserved.
// - a 1 written into the pull-down off register turns that line's pull-down off, zeros do nothing.
// - a 1 written into the pull-down on register turns that line's pull-down on, zeros do nothing.
// - the pull-down state register reads 0 for a line whose pull-down is on and 1 where it is off.
// - a 1 written into the gate-on register lets later output data writes reach that line.
// - a 1 written into the gate-off register stops output data writes from reaching that line.
`timescale 1ns/1ns
`default_nettype none
`include "iolm_regs.vh"

module iolm_top #(
  parameter LINES = 32,
  parameter DIV_WIDTH = `IOLM_DIV_WIDTH
) (
  input wire clk,
  input wire rst_n,
  input wire [31:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [31:0] reg_rdata,
  input wire [LINES-1:0] line_pin_in,
  input wire slow_clk_pin,
  input wire [LINES-1:0] pullup_active,
  output wire [LINES-1:0] line_filtered,
  output wire [LINES-1:0] periph_a_sel,
  output wire [LINES-1:0] periph_b_sel,
  output wire [LINES-1:0] periph_c_sel,
  output wire [LINES-1:0] periph_d_sel,
  output wire [LINES-1:0] pulldown_enable,
  output wire [LINES-1:0] debounce_select,
  output wire [LINES-1:0] output_write_gate,
  output wire write_protect_enable
);

  // one-hot line function codes, bit order {d, c, b, a}
  localparam [3:0] FSEL_A = 4'h1;
  localparam [3:0] FSEL_B = 4'h2;
  localparam [3:0] FSEL_C = 4'h4;
  localparam [3:0] FSEL_D = 4'h8;

  // address match, shared by every write and read decode
  function hit;
    input [31:0] addr;
    input [31:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  // set/clear update of a per-line state word: only bits written as 1 move
  // set and clear sit at separate addresses, so the two enables never meet
  function [LINES-1:0] set_clear;
    input [LINES-1:0] state;
    input set_en;
    input clr_en;
    input [LINES-1:0] mask;
    begin
      set_clear = state;
      if (set_en) begin
        set_clear = state | mask;
      end
      if (clr_en) begin
        set_clear = state & ~mask;
      end
    end
  endfunction

  // two select bits of one line to its one-hot function code
  function [3:0] fsel_decode;
    input sel_low;
    input sel_high;
    begin
      case ({sel_high, sel_low})
        2'h0: fsel_decode = FSEL_A;
        2'h1: fsel_decode = FSEL_B;
        2'h2: fsel_decode = FSEL_C;
        2'h3: fsel_decode = FSEL_D;
        default: fsel_decode = FSEL_A;
      endcase
    end
  endfunction

  // register state
  reg [LINES-1:0] func_sel_low_reg;
  reg [LINES-1:0] func_sel_high_reg;
  reg [LINES-1:0] debounce_sel_reg;
  reg [DIV_WIDTH-1:0] prescale_reg;
  reg [LINES-1:0] pulldown_on_reg;
  reg [LINES-1:0] out_gate_reg;
  reg wprot_reg;
  reg [31:0] rdata_reg;
  reg [31:0] rdata_next;

  // pin-facing outputs, each bit taken from a per-line flop below
  wire [LINES-1:0] periph_a_bits;
  wire [LINES-1:0] periph_b_bits;
  wire [LINES-1:0] periph_c_bits;
  wire [LINES-1:0] periph_d_bits;
  wire [LINES-1:0] line_out_bits;

  wire [LINES-1:0] wdata_lines;
  wire wr_func_low;
  wire wr_func_high;
  wire wr_filt_glitch;
  wire wr_filt_deb;
  wire wr_prescale;
  wire wr_pd_off;
  wire wr_pd_on;
  wire wr_gate_on;
  wire wr_gate_off;
  wire wr_wprot;
  wire wr_open;
  wire [LINES-1:0] line_sync;
  wire slck_sync;
  wire half_tick;

  assign wdata_lines = reg_wdata[LINES-1:0];

  // protected writes are simply dropped, there is no error response
  assign wr_open = reg_wr & ~wprot_reg;
  assign wr_func_low = wr_open & hit(reg_addr, `IOLM_FUNC_SEL_LOW_ADDR);
  assign wr_func_high = wr_open & hit(reg_addr, `IOLM_FUNC_SEL_HIGH_ADDR);
  assign wr_pd_off = wr_open & hit(reg_addr, `IOLM_PULLDOWN_OFF_ADDR);
  assign wr_pd_on = wr_open & hit(reg_addr, `IOLM_PULLDOWN_ON_ADDR);
  assign wr_gate_on = wr_open & hit(reg_addr, `IOLM_OUT_GATE_ON_ADDR);
  assign wr_gate_off = wr_open & hit(reg_addr, `IOLM_OUT_GATE_OFF_ADDR);

  // filter choice and prescale stay writable under protection
  assign wr_filt_glitch = reg_wr & hit(reg_addr, `IOLM_FILT_GLITCH_SEL_ADDR);
  assign wr_filt_deb = reg_wr & hit(reg_addr, `IOLM_FILT_DEBOUNCE_SEL_ADDR);
  assign wr_prescale = reg_wr & hit(reg_addr, `IOLM_DEB_PRESCALE_ADDR);
  assign wr_wprot = reg_wr & hit(reg_addr, `IOLM_WPROT_CTRL_ADDR);

  // write-protect control
  // the protect bit guards nothing of its own, so software can always lift it
  always @(posedge clk) begin
    if (!rst_n) begin
      wprot_reg <= `IOLM_WPROT_RST;
    end else if (wr_wprot) begin
      wprot_reg <= reg_wdata[`IOLM_WPROT_BIT];
    end
  end

  // function select words, plain read/write
  always @(posedge clk) begin
    if (!rst_n) begin
      func_sel_low_reg <= `IOLM_FUNC_SEL_RST;
      func_sel_high_reg <= `IOLM_FUNC_SEL_RST;
    end else begin
      if (wr_func_low) begin
        func_sel_low_reg <= wdata_lines;
      end
      if (wr_func_high) begin
        func_sel_high_reg <= wdata_lines;
      end
    end
  end

  // one hot function decode per line, one cycle behind the select words
  // a decode flop per line keeps every select output straight from a register
  genvar f;
  generate
    for (f = 0; f < LINES; f = f + 1) begin : g_func
      reg [3:0] onehot_reg;
      always @(posedge clk) begin
        if (!rst_n) begin
          onehot_reg <= 4'h0;
        end else begin
          onehot_reg <= fsel_decode(func_sel_low_reg[f], func_sel_high_reg[f]);
        end
      end
      assign periph_a_bits[f] = onehot_reg[0];
      assign periph_b_bits[f] = onehot_reg[1];
      assign periph_c_bits[f] = onehot_reg[2];
      assign periph_d_bits[f] = onehot_reg[3];
    end
  endgenerate

  // filter choice flop: 0 glitch filter, 1 debouncer
  always @(posedge clk) begin
    if (!rst_n) begin
      debounce_sel_reg <= `IOLM_FILT_SEL_RST;
    end else begin
      debounce_sel_reg <= set_clear(debounce_sel_reg, wr_filt_deb, wr_filt_glitch,
        wdata_lines);
    end
  end

  // debounce divider, reserved upper bits are never stored
  // a divider of zero gives one tick per slow-clock rise, the shortest period
  always @(posedge clk) begin
    if (!rst_n) begin
      prescale_reg <= `IOLM_DIV_RST;
    end else if (wr_prescale) begin
      prescale_reg <= reg_wdata[`IOLM_DIV_MSB:`IOLM_DIV_LSB];
    end
  end

  // pull-down state, 1 means resistor on
  always @(posedge clk) begin
    if (!rst_n) begin
      pulldown_on_reg <= `IOLM_PULLDOWN_RST;
    end else begin
      pulldown_on_reg <= set_clear(pulldown_on_reg, wr_pd_on, wr_pd_off,
        wdata_lines);
    end
  end

  // output-write gate, 1 lets output data writes reach the line
  always @(posedge clk) begin
    if (!rst_n) begin
      out_gate_reg <= `IOLM_OUT_GATE_RST;
    end else begin
      out_gate_reg <= set_clear(out_gate_reg, wr_gate_on, wr_gate_off,
        wdata_lines);
    end
  end

  // pins and slow clock come from outside the clock domain
  // three stages and an agreement flop cost four cycles on every line but never let a late pin
  // show two values within one cycle
  iolm_sync3 #(
    .WIDTH(LINES)
  ) u_line_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in(line_pin_in),
    .level_out(line_sync)
  );

  iolm_sync3 #(
    .WIDTH(1)
  ) u_slck_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin_in(slow_clk_pin),
    .level_out(slck_sync)
  );

  iolm_slck_div #(
    .DIV_WIDTH(DIV_WIDTH)
  ) u_slck_div (
    .clk(clk),
    .rst_n(rst_n),
    .slck_level(slck_sync),
    .div_value(prescale_reg),
    .half_tick(half_tick)
  );

  // a debounced line only changes after equal samples on two successive
  // half-period ticks, so pulses under half a debounce period are lost;
  // the agreement in the synchroniser already rejects sub-cycle glitches
  // limitation: a new divider value applies from the next slow-clock rise, in the middle of a running half period
  genvar i;
  generate
    for (i = 0; i < LINES; i = i + 1) begin : g_filter
      reg sample_reg;
      reg level_reg;
      reg out_reg;
      always @(posedge clk) begin
        if (!rst_n) begin
          sample_reg <= 1'b0;
          level_reg <= 1'b0;
        end else if (half_tick) begin
          sample_reg <= line_sync[i];
          if (line_sync[i] == sample_reg) begin
            level_reg <= line_sync[i];
          end
        end
      end

      always @(posedge clk) begin
        if (!rst_n) begin
          out_reg <= 1'b0;
        end else if (debounce_sel_reg[i]) begin
          out_reg <= level_reg;
        end else begin
          out_reg <= line_sync[i];
        end
      end
      assign line_out_bits[i] = out_reg;
    end
  endgenerate

  // the pull-up flops live outside; only their inverted state is reported
  // status words show the live state flops, so a read right after a write
  // already returns the new setting
  // read mux; write-only and unmapped addresses read as zero
  always @* begin
    rdata_next = `IOLM_READ_NONE;
    if (hit(reg_addr, `IOLM_PULLUP_STATE_ADDR)) begin
      rdata_next[LINES-1:0] = ~pullup_active;
    end else if (hit(reg_addr, `IOLM_FUNC_SEL_LOW_ADDR)) begin
      rdata_next[LINES-1:0] = func_sel_low_reg;
    end else if (hit(reg_addr, `IOLM_FUNC_SEL_HIGH_ADDR)) begin
      rdata_next[LINES-1:0] = func_sel_high_reg;
    end else if (hit(reg_addr, `IOLM_FILT_SEL_STATUS_ADDR)) begin
      rdata_next[LINES-1:0] = debounce_sel_reg;
    end else if (hit(reg_addr, `IOLM_DEB_PRESCALE_ADDR)) begin
      rdata_next[`IOLM_DIV_MSB:`IOLM_DIV_LSB] = prescale_reg;
    end else if (hit(reg_addr, `IOLM_PULLDOWN_STATE_ADDR)) begin
      rdata_next[LINES-1:0] = ~pulldown_on_reg;
    end else if (hit(reg_addr, `IOLM_OUT_GATE_STATE_ADDR)) begin
      rdata_next[LINES-1:0] = out_gate_reg;
    end else if (hit(reg_addr, `IOLM_WPROT_CTRL_ADDR)) begin
      rdata_next[`IOLM_WPROT_BIT] = wprot_reg;
    end
  end

  // read data holds only for the cycle after the strobe
  always @(posedge clk) begin
    if (!rst_n) begin
      rdata_reg <= `IOLM_READ_NONE;
    end else if (reg_rd) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= `IOLM_READ_NONE;
    end
  end

  assign reg_rdata = rdata_reg;
  assign line_filtered = line_out_bits;
  assign periph_a_sel = periph_a_bits;
  assign periph_b_sel = periph_b_bits;
  assign periph_c_sel = periph_c_bits;
  assign periph_d_sel = periph_d_bits;
  assign pulldown_enable = pulldown_on_reg;
  assign debounce_select = debounce_sel_reg;
  assign output_write_gate = out_gate_reg;
  assign write_protect_enable = wprot_reg;

endmodule

`default_nettype wire

/* design/iolm_regs.vh */
// register map, field positions and reset values of the i/o line mux/filter/pull block
`ifndef IOLM_REGS_VH
`define IOLM_REGS_VH

// byte addresses of the register bank
`define IOLM_PULLUP_STATE_ADDR 32'h400e0e68
`define IOLM_FUNC_SEL_LOW_ADDR 32'h400e0e70
`define IOLM_FUNC_SEL_HIGH_ADDR 32'h400e0e74
`define IOLM_FILT_GLITCH_SEL_ADDR 32'h400e0e80
`define IOLM_FILT_DEBOUNCE_SEL_ADDR 32'h400e0e84
`define IOLM_FILT_SEL_STATUS_ADDR 32'h400e0e88
`define IOLM_DEB_PRESCALE_ADDR 32'h400e0e8c
`define IOLM_PULLDOWN_OFF_ADDR 32'h400e0e90
`define IOLM_PULLDOWN_ON_ADDR 32'h400e0e94
`define IOLM_PULLDOWN_STATE_ADDR 32'h400e0e98
`define IOLM_OUT_GATE_ON_ADDR 32'h400e0ea0
`define IOLM_OUT_GATE_OFF_ADDR 32'h400e0ea4
`define IOLM_OUT_GATE_STATE_ADDR 32'h400e0ea8
`define IOLM_WPROT_CTRL_ADDR 32'h400e0ef0

// prescale field
`define IOLM_DIV_MSB 13
`define IOLM_DIV_LSB 0
`define IOLM_DIV_WIDTH 14

// write-protect control field
`define IOLM_WPROT_BIT 0

// reset values
`define IOLM_FUNC_SEL_RST 32'h00000000
`define IOLM_FILT_SEL_RST 32'h00000000
`define IOLM_DIV_RST 14'h0000
`define IOLM_PULLDOWN_RST 32'h00000000
`define IOLM_OUT_GATE_RST 32'h00000000
`define IOLM_WPROT_RST 1'h0

// read value of unmapped and write-only addresses
`define IOLM_READ_NONE 32'h00000000

`endif

/* design/iolm_sync3.v */
// three-stage pin synchroniser; a change counts once stages two and three agree
`timescale 1ns/1ns
`default_nettype none

module iolm_sync3 #(
  parameter WIDTH = 32
) (
  input wire clk,
  input wire rst_n,
  input wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] level_out
);

  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;
  reg [WIDTH-1:0] stage3_reg;

  // stage1 feeds only stage2 so metastability never reaches a decision
  always @(posedge clk) begin
    if (!rst_n) begin
      stage1_reg <= {WIDTH{1'b0}};
      stage2_reg <= {WIDTH{1'b0}};
      stage3_reg <= {WIDTH{1'b0}};
    end else begin
      stage1_reg <= pin_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_agree
      reg agree_reg;
      always @(posedge clk) begin
        if (!rst_n) begin
          agree_reg <= 1'b0;
        end else if (stage2_reg[i] == stage3_reg[i]) begin
          agree_reg <= stage3_reg[i];
        end
      end
      assign level_out[i] = agree_reg;
    end
  endgenerate

endmodule

`default_nettype wire

/* design/iolm_slck_div.v */
// slow-clock edge counter giving one tick per half debounce period
`timescale 1ns/1ns
`default_nettype none

module iolm_slck_div #(
  parameter DIV_WIDTH = 14
) (
  input wire clk,
  input wire rst_n,
  input wire slck_level,
  input wire [DIV_WIDTH-1:0] div_value,
  output wire half_tick
);

  reg slck_prev_reg;
  reg [DIV_WIDTH-1:0] edge_cnt_reg;
  reg tick_reg;
  wire slck_rise;

  assign slck_rise = slck_level & ~slck_prev_reg;

  // period is (div+1)*2 slow clocks, so a half period is div+1 rising edges
  always @(posedge clk) begin
    if (!rst_n) begin
      slck_prev_reg <= 1'b0;
      edge_cnt_reg <= {DIV_WIDTH{1'b0}};
      tick_reg <= 1'b0;
    end else begin
      slck_prev_reg <= slck_level;
      tick_reg <= 1'b0;
      if (slck_rise) begin
        if (edge_cnt_reg >= div_value) begin
          edge_cnt_reg <= {DIV_WIDTH{1'b0}};
          tick_reg <= 1'b1;
        end else begin
          edge_cnt_reg <= edge_cnt_reg + {{(DIV_WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  assign half_tick = tick_reg;

endmodule

`default_nettype wire

/* tb/iolm_pins.sv */
// pin-side model: external line levels and a free-running slow clock
`timescale 1ns/1ns
`default_nettype none
module iolm_pins #(
  parameter int HALF = 4
) (
  input wire clk,
  input wire [31:0] pin_set,
  output logic [31:0] line_pin_in,
  output logic slow_clk_pin
);
  int cnt = 0;
  initial begin
    line_pin_in = 32'h0;
    slow_clk_pin = 1'b0;
  end
  // pins move off the edge, like a truly unsynchronised source
  always @(posedge clk) begin
    line_pin_in <= #7 pin_set;
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) begin
      slow_clk_pin <= #13 ~slow_clk_pin;
    end
  end
endmodule
`default_nettype wire

/* tb/iolm_top_asserts.sv */
// port checker for the line mux, filter and pull block
`timescale 1ns/1ns
`default_nettype none
`include "iolm_regs.vh"
module iolm_chk #(
  parameter LINES = 32
) (
  input wire clk,
  input wire rst_n,
  input wire [31:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire [LINES-1:0] pullup_active,
  input wire [LINES-1:0] periph_a_sel,
  input wire [LINES-1:0] periph_b_sel,
  input wire [LINES-1:0] periph_c_sel,
  input wire [LINES-1:0] periph_d_sel,
  input wire [LINES-1:0] pulldown_enable,
  input wire [LINES-1:0] debounce_select,
  input wire [LINES-1:0] output_write_gate,
  input wire write_protect_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire wr_ok = reg_wr && !write_protect_enable;
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0) else $error("stray read data");
  pd_read_a: assert property (reg_rd && reg_addr == `IOLM_PULLDOWN_STATE_ADDR
    |=> reg_rdata == ~$past(pulldown_enable)) else $error("pull-down status wrong");
  pu_read_a: assert property (reg_rd && reg_addr == `IOLM_PULLUP_STATE_ADDR
    |=> reg_rdata == ~$past(pullup_active)) else $error("pull-up status wrong");
  filt_read_a: assert property (reg_rd && reg_addr == `IOLM_FILT_SEL_STATUS_ADDR
    |=> reg_rdata == $past(debounce_select)) else $error("filter status wrong");
  func_low_a: assert property (wr_ok && reg_addr == `IOLM_FUNC_SEL_LOW_ADDR
    |-> ##2 (periph_b_sel | periph_d_sel) == $past(reg_wdata, 2)) else $error("b/d decode");
  func_high_a: assert property (wr_ok && reg_addr == `IOLM_FUNC_SEL_HIGH_ADDR
    |-> ##2 (periph_c_sel | periph_d_sel) == $past(reg_wdata, 2)) else $error("c/d decode");
  decode_onehot_a: assert property ($past(rst_n) |->
    ((periph_a_sel | periph_b_sel | periph_c_sel | periph_d_sel) == '1) &&
    ((periph_a_sel & (periph_b_sel | periph_c_sel | periph_d_sel)) == '0) &&
    ((periph_b_sel & (periph_c_sel | periph_d_sel)) == '0) &&
    ((periph_c_sel & periph_d_sel) == '0)) else $error("not one-hot");
  pd_set_a: assert property (wr_ok && reg_addr == `IOLM_PULLDOWN_ON_ADDR
    |=> pulldown_enable == ($past(pulldown_enable) | $past(reg_wdata))) else $error("pd on");
  pd_clr_a: assert property (wr_ok && reg_addr == `IOLM_PULLDOWN_OFF_ADDR
    |=> pulldown_enable == ($past(pulldown_enable) & ~$past(reg_wdata))) else $error("pd off");
  gate_set_a: assert property (wr_ok && reg_addr == `IOLM_OUT_GATE_ON_ADDR
    |=> output_write_gate == ($past(output_write_gate) | $past(reg_wdata))) else $error("gate");
  gate_clr_a: assert property (wr_ok && reg_addr == `IOLM_OUT_GATE_OFF_ADDR
    |=> output_write_gate == ($past(output_write_gate) & ~$past(reg_wdata)))
    else $error("gate off");
  deb_clr_a: assert property (reg_wr && reg_addr == `IOLM_FILT_GLITCH_SEL_ADDR
    |=> debounce_select == ($past(debounce_select) & ~$past(reg_wdata))) else $error("deb clr");
  deb_set_a: assert property (reg_wr && reg_addr == `IOLM_FILT_DEBOUNCE_SEL_ADDR
    |=> debounce_select == ($past(debounce_select) | $past(reg_wdata))) else $error("deb sel");
  prot_hold_a: assert property (reg_wr && write_protect_enable
    |=> $stable(pulldown_enable) && $stable(output_write_gate)) else $error("protect leak");
  state_hold_a: assert property (!reg_wr |=> $stable(pulldown_enable) &&
    $stable(debounce_select) && $stable(output_write_gate)) else $error("state drift");
endmodule
`default_nettype wire

/* tb/iolm_top_tb_top.sv */
// testbench: register access, pulls, function mux, filters, gating, protection
`timescale 1ns/1ns
`default_nettype none
`include "iolm_regs.vh"
module iolm_top_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] reg_addr = 32'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] pin_set = 32'h0;
  logic [31:0] pullup_active = 32'h0;
  wire [31:0] reg_rdata, line_pin_in, line_filtered, pa, pb, pc, pd;
  wire [31:0] pulldown_enable, debounce_select, output_write_gate;
  wire slow_clk_pin, write_protect_enable;
  int errors = 0;
  int cmp_count = 0;
  initial begin
    forever #25 clk = ~clk;
  end
  iolm_top DUT (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_pin_in(line_pin_in),
    .slow_clk_pin(slow_clk_pin), .pullup_active(pullup_active), .line_filtered(line_filtered),
    .periph_a_sel(pa), .periph_b_sel(pb), .periph_c_sel(pc), .periph_d_sel(pd),
    .pulldown_enable(pulldown_enable), .debounce_select(debounce_select),
    .output_write_gate(output_write_gate), .write_protect_enable(write_protect_enable));
  // slow clock period of 8 cycles keeps debounce waits short
  iolm_pins #(.HALF(4)) pins (.clk(clk), .pin_set(pin_set), .line_pin_in(line_pin_in),
    .slow_clk_pin(slow_clk_pin));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, exp);
  endtask
  task t_reset;
    rd(`IOLM_PULLDOWN_STATE_ADDR, 32'hffffffff);
    rd(`IOLM_FILT_SEL_STATUS_ADDR, 32'h0);
    rd(`IOLM_DEB_PRESCALE_ADDR, 32'h0);
    chk(pa, 32'hffffffff);
    rd(32'h400e0e7c, 32'h0);
    rd(`IOLM_PULLDOWN_ON_ADDR, 32'h0);
  endtask
  task t_pulls;
    wr(`IOLM_PULLDOWN_ON_ADDR, 32'h000000f1);
    wr(`IOLM_PULLDOWN_OFF_ADDR, 32'h00000011);
    @(negedge clk);
    chk(pulldown_enable, 32'h000000e0);
    rd(`IOLM_PULLDOWN_STATE_ADDR, 32'hffffff1f);
    @(posedge clk);
    pullup_active <= 32'h0000a5a5;
    rd(`IOLM_PULLUP_STATE_ADDR, 32'hffff5a5a);
  endtask
  task t_func;
    wr(`IOLM_FUNC_SEL_LOW_ADDR, 32'h0000000a);
    wr(`IOLM_FUNC_SEL_HIGH_ADDR, 32'h0000000c);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({16'h0, pd[3:0], pc[3:0], pb[3:0], pa[3:0]}, 32'h00008421);
    rd(`IOLM_FUNC_SEL_LOW_ADDR, 32'h0000000a);
  endtask
  task t_filter;
    logic [31:0] seen;
    int n;
    seen = 32'h0;
    wr(`IOLM_DEB_PRESCALE_ADDR, 32'hffffffff);
    rd(`IOLM_DEB_PRESCALE_ADDR, 32'h00003fff);
    wr(`IOLM_DEB_PRESCALE_ADDR, 32'h00000001);
    wr(`IOLM_FILT_DEBOUNCE_SEL_ADDR, 32'h00000003);
    wr(`IOLM_FILT_GLITCH_SEL_ADDR, 32'h00000001);
    rd(`IOLM_FILT_SEL_STATUS_ADDR, 32'h00000002);
    chk(debounce_select, 32'h00000002);
    @(posedge clk);
    pin_set <= 32'h3;
    repeat (4) @(posedge clk);
    pin_set <= 32'h0;
    repeat (40) @(negedge clk) seen = seen | line_filtered;
    chk(seen & 32'h3, 32'h1);
    @(posedge clk);
    pin_set <= 32'h2;
    for (n = 0; n < 80 && line_filtered[1] !== 1'b1; n++) @(negedge clk);
    chk({31'h0, n >= 16 && n < 80}, 32'h1);
    if (n >= 80) begin
      wrap_up();
    end
    @(posedge clk);
    pin_set <= 32'h0;
  endtask
  task t_gate;
    wr(`IOLM_OUT_GATE_ON_ADDR, 32'h00000005);
    wr(`IOLM_OUT_GATE_OFF_ADDR, 32'h00000001);
    @(negedge clk);
    chk(output_write_gate, 32'h00000004);
    rd(`IOLM_OUT_GATE_STATE_ADDR, 32'h00000004);
  endtask
  task t_protect;
    wr(`IOLM_WPROT_CTRL_ADDR, 32'h1);
    wr(`IOLM_PULLDOWN_ON_ADDR, 32'hffffffff);
    wr(`IOLM_PULLDOWN_OFF_ADDR, 32'hffffffff);
    wr(`IOLM_OUT_GATE_ON_ADDR, 32'hffffffff);
    wr(`IOLM_OUT_GATE_OFF_ADDR, 32'hffffffff);
    wr(`IOLM_FUNC_SEL_HIGH_ADDR, 32'h0);
    @(negedge clk);
    chk(pulldown_enable | output_write_gate, 32'h000000e4);
    chk({31'h0, write_protect_enable}, 32'h1);
    rd(`IOLM_WPROT_CTRL_ADDR, 32'h1);
    rd(`IOLM_FUNC_SEL_HIGH_ADDR, 32'h0000000c);
    wr(`IOLM_WPROT_CTRL_ADDR, 32'h0);
    wr(`IOLM_PULLDOWN_ON_ADDR, 32'h1);
    @(negedge clk);
    chk(pulldown_enable, 32'h000000e1);
  endtask
  task wrap_up;
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_pulls();
    t_func();
    t_filter();
    t_gate();
    t_protect();
    wrap_up();
  end
endmodule
bind iolm_top iolm_chk #(.LINES(LINES)) u_chk (.clk(clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .pullup_active(pullup_active), .periph_a_sel(periph_a_sel),
  .periph_b_sel(periph_b_sel), .periph_c_sel(periph_c_sel), .periph_d_sel(periph_d_sel),
  .pulldown_enable(pulldown_enable), .debounce_select(debounce_select),
  .output_write_gate(output_write_gate), .write_protect_enable(write_protect_enable));
`default_nettype wire
